// file: ccal_ctrl.sv
// comparator switch and offset calibration control, axi4-lite register slave
// assumes comparator results arrive asynchronously; switches are level controls
//
// Summary of operation
// - in calibration ref select 1 picks shared node, 0 the inverting node.
// - first offset mode forces shared and inverting switches and selects to one.
// - second offset mode forces shared and second switches and selects to one.
// - after calibration, forced selects return to the stored software values.
// - shared select one forces both amplifier route bits to zero.
// - shared select zero with amp one route forces amp two route zero.
// - first comparator disabled leaves its output and internal pins as gpio, the shared pin too if the second is disabled.
// - shared select picks amplifier output at zero, shared pin at one.
// - inverting select picks high reference at zero, internal pin at one.
// - first output enable drives result onto its output pin.
// - second comparator disabled leaves its output and internal pins as gpio, the shared pin too if the first is disabled.
// - noninverting select picks low reference at zero, internal pin at one.
// - second output enable drives result onto its output pin.
// - each comparator has a five-bit read-write trim in the low bits.
// - each result is readable as a read-only positive-logic status bit.
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/10ps
`include "ccal_defs.svh"
module ccal_ctrl
	import ccal_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [1:0]  comparator_result,
	output ccal_switch_t     switches,
	output ccal_cmp_cfg_t    trim_cfg_first,
	output ccal_cmp_cfg_t    trim_cfg_second,
	output ccal_pin_t        pin_owned,
	output logic             first_output_pin_o,
	output logic             second_output_pin_o
);
	// stored software values, never overwritten by the forcing logic
	ccal_cmp_cfg_t   cfg1, cfg2, next_cfg1, next_cfg2;
	logic            shared_sel, amp_one, amp_two;
	logic            next_shared_sel, next_amp_one, next_amp_two;
	// effective values seen by the switches and by reads
	ccal_cmp_cfg_t   eff1, eff2;
	logic            eff_shared, eff_amp_one, eff_amp_two;
	logic [1:0]      result;
	ccal_switch_t    sw_dec;
	ccal_pin_t       pin_dec;

	ccal_bus_state_t wstate, next_wstate, rstate, next_rstate;
	logic            aw_held, w_held, next_aw_held, next_w_held;
	logic [11:0]     waddr, next_waddr;
	logic [31:0]     wdata, next_wdata;
	logic [3:0]      wstrb, next_wstrb;
	logic [1:0]      bresp, next_bresp, rresp, next_rresp;
	logic [31:0]     rdata, next_rdata;
	logic            do_write;

	function automatic logic addr_known(input logic [11:0] a);
		return a == `CCAL_OFF_FIRST_COMPARATOR_TRIM || a == `CCAL_OFF_FIRST_COMPARATOR_CFG ||
			a == `CCAL_OFF_SECOND_COMPARATOR_TRIM || a == `CCAL_OFF_SECOND_COMPARATOR_CFG ||
			a == `CCAL_OFF_ROUTE;
	endfunction

	function automatic logic [31:0] trim_word(input ccal_cmp_cfg_t c, input logic res);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`CCAL_TRIM_LSB +: `CCAL_TRIM_W] = c.trim;
		w[`CCAL_RS_BIT]  = c.ref_select;
		w[`CCAL_OFM_BIT] = c.offset_mode;
		w[`CCAL_RES_BIT] = res;
		return w;
	endfunction

	function automatic logic [31:0] cfg_word(input ccal_cmp_cfg_t c);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`CCAL_EN_BIT]  = c.enable;
		w[`CCAL_SEL_BIT] = c.input_select;
		w[`CCAL_OE_BIT]  = c.output_pin_enable;
		return w;
	endfunction

	// both comparators reset through the same field mapping
	function automatic ccal_cmp_cfg_t cfg_reset(input logic [2:0] rst_bits);
		ccal_cmp_cfg_t c;
		c                   = '0;
		c.trim              = `CCAL_TRIM_RST;
		c.enable            = rst_bits[`CCAL_EN_BIT];
		c.input_select      = rst_bits[`CCAL_SEL_BIT];
		c.output_pin_enable = rst_bits[`CCAL_OE_BIT];
		return c;
	endfunction

	function automatic logic [31:0] route_word(input logic sh, input logic a1, input logic a2);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`CCAL_SHSEL_BIT] = sh;
		w[`CCAL_A1_BIT]    = a1;
		w[`CCAL_A2_BIT]    = a2;
		return w;
	endfunction

	ccal_sync u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in (comparator_result),
		.sync_out (result)
	);

	// forcing during calibration and amplifier interlock
	always_comb begin
		eff1 = cfg1;
		eff2 = cfg2;
		eff_shared = shared_sel;
		if (cfg1.offset_mode) begin
			eff_shared        = 1'b1;
			eff1.input_select = 1'b1;
		end
		if (cfg2.offset_mode) begin
			eff_shared        = 1'b1;
			eff2.input_select = 1'b1;
		end
		eff_amp_one = amp_one & !eff_shared;
		eff_amp_two = amp_two & !eff_shared & !amp_one;
	end

	ccal_route u_route (
		.cfg1              (eff1),
		.cfg2              (eff2),
		.shared_sel        (eff_shared),
		.amp_one_route_bit (eff_amp_one),
		.amp_two_route_bit (eff_amp_two),
		.sw                (sw_dec),
		.pin_own           (pin_dec)
	);

	// write channel: address and data taken in either order
	always_comb begin
		next_wstate  = wstate;
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_waddr   = waddr;
		next_wdata   = wdata;
		next_wstrb   = wstrb;
		next_bresp   = bresp;
		do_write     = 1'b0;
		// both readies drop while a response waits, so one write is in flight
		s_axi_awready = (wstate == CCAL_IDLE) && !aw_held;
		s_axi_wready  = (wstate == CCAL_IDLE) && !w_held;
		unique case (wstate)
			CCAL_IDLE: begin
				if (s_axi_awvalid && !aw_held) begin
					next_aw_held = 1'b1;
					next_waddr   = s_axi_awaddr;
				end
				if (s_axi_wvalid && !w_held) begin
					next_w_held = 1'b1;
					next_wdata  = s_axi_wdata;
					next_wstrb  = s_axi_wstrb;
				end
				if (next_aw_held && next_w_held) begin
					do_write     = addr_known(next_waddr);
					next_bresp   = do_write ? `CCAL_RESP_OKAY : `CCAL_RESP_SLVERR;
					next_aw_held = 1'b0;
					next_w_held  = 1'b0;
					next_wstate  = CCAL_RESP;
				end
			end
			CCAL_RESP: begin
				if (s_axi_bready) begin
					next_wstate = CCAL_IDLE;
				end
			end
		endcase
	end

	// register storage; only byte lane 0 carries bits
	always_comb begin
		next_cfg1       = cfg1;
		next_cfg2       = cfg2;
		next_shared_sel = shared_sel;
		next_amp_one    = amp_one;
		next_amp_two    = amp_two;
		if (do_write && next_wstrb[0]) begin
			unique case (next_waddr)
				`CCAL_OFF_FIRST_COMPARATOR_TRIM: begin
					next_cfg1.trim        = next_wdata[`CCAL_TRIM_LSB +: `CCAL_TRIM_W];
					next_cfg1.ref_select  = next_wdata[`CCAL_RS_BIT];
					next_cfg1.offset_mode = next_wdata[`CCAL_OFM_BIT];
				end
				`CCAL_OFF_SECOND_COMPARATOR_TRIM: begin
					next_cfg2.trim        = next_wdata[`CCAL_TRIM_LSB +: `CCAL_TRIM_W];
					next_cfg2.ref_select  = next_wdata[`CCAL_RS_BIT];
					next_cfg2.offset_mode = next_wdata[`CCAL_OFM_BIT];
				end
				`CCAL_OFF_FIRST_COMPARATOR_CFG: begin
					next_cfg1.enable            = next_wdata[`CCAL_EN_BIT];
					next_cfg1.input_select      = next_wdata[`CCAL_SEL_BIT];
					next_cfg1.output_pin_enable = next_wdata[`CCAL_OE_BIT];
				end
				`CCAL_OFF_SECOND_COMPARATOR_CFG: begin
					next_cfg2.enable            = next_wdata[`CCAL_EN_BIT];
					next_cfg2.input_select      = next_wdata[`CCAL_SEL_BIT];
					next_cfg2.output_pin_enable = next_wdata[`CCAL_OE_BIT];
				end
				`CCAL_OFF_ROUTE: begin
					next_shared_sel = next_wdata[`CCAL_SHSEL_BIT];
					next_amp_one    = next_wdata[`CCAL_A1_BIT];
					next_amp_two    = next_wdata[`CCAL_A2_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// read channel; reads show the effective, forced values
	always_comb begin
		next_rstate = rstate;
		next_rdata  = rdata;
		next_rresp  = rresp;
		// data captured at the address edge, so a later write cannot tear it
		s_axi_arready = (rstate == CCAL_IDLE);
		unique case (rstate)
			CCAL_IDLE: begin
				if (s_axi_arvalid) begin
					next_rstate = CCAL_RESP;
					next_rresp  = addr_known(s_axi_araddr) ? `CCAL_RESP_OKAY
						: `CCAL_RESP_SLVERR;
					next_rdata  = 32'h0000_0000;
					unique case (s_axi_araddr)
						`CCAL_OFF_FIRST_COMPARATOR_TRIM: next_rdata = trim_word(eff1, result[0]);
						`CCAL_OFF_SECOND_COMPARATOR_TRIM: next_rdata = trim_word(eff2, result[1]);
						`CCAL_OFF_FIRST_COMPARATOR_CFG:  next_rdata = cfg_word(eff1);
						`CCAL_OFF_SECOND_COMPARATOR_CFG:  next_rdata = cfg_word(eff2);
						`CCAL_OFF_ROUTE:
							next_rdata = route_word(eff_shared, eff_amp_one, eff_amp_two);
						default: next_rdata = 32'h0000_0000;
					endcase
				end
			end
			CCAL_RESP: begin
				if (s_axi_rready) begin
					next_rstate = CCAL_IDLE;
				end
			end
		endcase
	end

	// write channel state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wstate  <= CCAL_IDLE;
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			waddr   <= 12'h000;
			wdata   <= 32'h0000_0000;
			wstrb   <= 4'h0;
			bresp   <= `CCAL_RESP_OKAY;
		end else begin
			wstate  <= next_wstate;
			aw_held <= next_aw_held;
			w_held  <= next_w_held;
			waddr   <= next_waddr;
			wdata   <= next_wdata;
			wstrb   <= next_wstrb;
			bresp   <= next_bresp;
		end
	end

	// read channel state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rstate <= CCAL_IDLE;
			rresp  <= `CCAL_RESP_OKAY;
			rdata  <= 32'h0000_0000;
		end else begin
			rstate <= next_rstate;
			rresp  <= next_rresp;
			rdata  <= next_rdata;
		end
	end

	// stored comparator settings; the forcing logic only reads them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg1 <= cfg_reset(`CCAL_CFG1_RST);
			cfg2 <= cfg_reset(`CCAL_CFG2_RST);
		end else begin
			cfg1 <= next_cfg1;
			cfg2 <= next_cfg2;
		end
	end

	// stored route selects, masked by the interlock only on the way out
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shared_sel <= 1'b0;
			amp_one    <= 1'b0;
			amp_two    <= 1'b0;
		end else begin
			shared_sel <= next_shared_sel;
			amp_one    <= next_amp_one;
			amp_two    <= next_amp_two;
		end
	end

	always_comb begin
		s_axi_bvalid    = (wstate == CCAL_RESP);
		s_axi_bresp     = bresp;
		s_axi_rvalid    = (rstate == CCAL_RESP);
		s_axi_rresp     = rresp;
		s_axi_rdata     = rdata;
		switches        = sw_dec;
		trim_cfg_first  = eff1;
		trim_cfg_second = eff2;
		pin_owned       = pin_dec;
		first_output_pin_o  = pin_dec.first_output_pin & result[0];
		second_output_pin_o = pin_dec.second_output_pin & result[1];
	end
endmodule

// file: ccal_defs.svh
// register offsets, field positions and reset values of the comparator control block
// assumes a 32-bit axi4-lite slave with word-aligned registers
`ifndef CCAL_DEFS_SVH
`define CCAL_DEFS_SVH

`define CCAL_OFF_FIRST_COMPARATOR_TRIM   12'h000
`define CCAL_OFF_FIRST_COMPARATOR_CFG    12'h004
`define CCAL_OFF_SECOND_COMPARATOR_TRIM   12'h008
`define CCAL_OFF_SECOND_COMPARATOR_CFG    12'h00C
`define CCAL_OFF_ROUTE       12'h010

// trim registers: [4:0] trim, [5] ref select, [6] offset mode, [7] result (ro)
`define CCAL_TRIM_LSB        0
`define CCAL_TRIM_W          5
`define CCAL_RS_BIT          5
`define CCAL_OFM_BIT         6
`define CCAL_RES_BIT         7
// cfg registers: [0] enable, [1] input select, [2] output pin enable
`define CCAL_EN_BIT          0
`define CCAL_SEL_BIT         1
`define CCAL_OE_BIT          2
// route register: [0] shared select, [1] amp one route, [2] amp two route
`define CCAL_SHSEL_BIT       0
`define CCAL_A1_BIT          1
`define CCAL_A2_BIT          2

`define CCAL_TRIM_RST        5'h10
`define CCAL_CFG1_RST        3'h0
`define CCAL_CFG2_RST        3'h2

`define CCAL_RESP_OKAY       2'h0
`define CCAL_RESP_SLVERR     2'h2

`endif

// file: ccal_pkg.sv
// types shared by the comparator control block
// assumes ccal_defs.svh is available on the include path
package ccal_pkg;

	typedef struct packed {
		logic [4:0] trim;
		logic       ref_select;
		logic       offset_mode;
		logic       enable;
		logic       input_select;
		logic       output_pin_enable;
	} ccal_cmp_cfg_t;

	typedef struct packed {
		logic shared_node_switch;
		logic first_input_switch;
		logic second_input_switch;
		logic ref_switch_a;
		logic ref_switch_b;
		logic common_mode_short_switch;
		logic amp_one_route_switch;
		logic amp_two_route_switch;
	} ccal_switch_t;

	typedef struct packed {
		logic shared_input_pin;
		logic first_output_pin;
		logic second_output_pin;
		logic first_internal_input_pin;
		logic second_internal_input_pin;
	} ccal_pin_t;

	typedef enum logic [1:0] {
		CCAL_IDLE,
		CCAL_RESP
	} ccal_bus_state_t;

endpackage

// file: ccal_sync.sv
// two-flop synchroniser for the two comparator results
// assumes the results are asynchronous analog levels
`timescale 1ns/10ps
module ccal_sync
	import ccal_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [1:0] async_in,
	output logic      [1:0] sync_out
);
	logic [1:0] stage1;
	logic [1:0] next_stage1;
	logic [1:0] next_sync_out;

	always_comb begin
		next_stage1   = async_in;
		next_sync_out = stage1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage1   <= 2'h0;
			sync_out <= 2'h0;
		end else begin
			stage1   <= next_stage1;
			sync_out <= next_sync_out;
		end
	end
endmodule

// file: ccal_route.sv
// combinational switch and pin-sharing decode from the effective selects
// assumes inputs are already the forced, effective configuration
`timescale 1ns/10ps
module ccal_route
	import ccal_pkg::*;
(
	input  wire ccal_cmp_cfg_t cfg1,
	input  wire ccal_cmp_cfg_t cfg2,
	input  wire logic          shared_sel,
	input  wire logic          amp_one_route_bit,
	input  wire logic          amp_two_route_bit,
	output ccal_switch_t       sw,
	output ccal_pin_t          pin_own
);
	logic any_en;

	always_comb begin
		any_en = cfg1.enable | cfg2.enable;
		sw     = '0;
		sw.shared_node_switch   = shared_sel;
		sw.first_input_switch   = cfg1.input_select;
		sw.second_input_switch  = cfg2.input_select;
		sw.amp_one_route_switch = amp_one_route_bit;
		sw.amp_two_route_switch = amp_two_route_bit;
		sw.ref_switch_a         = 1'b1;
		sw.ref_switch_b         = 1'b1;
		if (cfg1.offset_mode) begin
			sw.ref_switch_a = cfg1.ref_select;
			sw.ref_switch_b = !cfg1.ref_select;
			sw.common_mode_short_switch = 1'b1;
		end else if (cfg2.offset_mode) begin
			sw.ref_switch_a = cfg2.ref_select;
			sw.ref_switch_b = !cfg2.ref_select;
			sw.common_mode_short_switch = 1'b1;
		end
		pin_own.shared_input_pin          = any_en & shared_sel;
		pin_own.first_internal_input_pin  = cfg1.enable & cfg1.input_select;
		pin_own.second_internal_input_pin = cfg2.enable & cfg2.input_select;
		pin_own.first_output_pin  = cfg1.enable & cfg1.output_pin_enable;
		pin_own.second_output_pin = cfg2.enable & cfg2.output_pin_enable;
	end
endmodule

// file: ccal_ctrl_assertions.sv
// concurrent checks on the comparator control block outputs
// assumes it is bound to ccal_ctrl and sees only its ports
`timescale 1ns/10ps
module ccal_ctrl_assertions
	import ccal_pkg::*;
(
	input wire logic          aclk,
	input wire logic          aresetn,
	input wire logic [1:0]    comparator_result,
	input wire ccal_switch_t  switches,
	input wire ccal_cmp_cfg_t trim_cfg_first,
	input wire ccal_cmp_cfg_t trim_cfg_second,
	input wire ccal_pin_t     pin_owned,
	input wire logic          first_output_pin_o,
	input wire logic          second_output_pin_o
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	wire cal1 = trim_cfg_first.offset_mode;
	wire cal2 = trim_cfg_second.offset_mode;
	wire sh   = switches.shared_node_switch;
	wire en1  = trim_cfg_first.enable;
	wire en2  = trim_cfg_second.enable;

	a_short_first: assert property (cal1 |-> switches.common_mode_short_switch)
		else $error("short switch open in calibration");
	a_ref_pick: assert property (cal1 |-> switches.ref_switch_a == trim_cfg_first.ref_select
		&& switches.ref_switch_b != trim_cfg_first.ref_select)
		else $error("reference switch wrong");
	a_cal_first: assert property (cal1 |-> sh && switches.first_input_switch
		&& trim_cfg_first.input_select)
		else $error("first calibration not forced");
	a_cal_second: assert property (cal2 |-> sh && switches.second_input_switch
		&& trim_cfg_second.input_select)
		else $error("second calibration not forced");
	a_amp_open: assert property (sh |-> !switches.amp_one_route_switch
		&& !switches.amp_two_route_switch)
		else $error("amplifier route closed with shared pin");
	a_amp_excl: assert property (!sh && switches.amp_one_route_switch
		|-> !switches.amp_two_route_switch)
		else $error("both amplifier routes closed");
	a_gpio_first: assert property (!en1 |-> !pin_owned.first_output_pin
		&& !pin_owned.first_internal_input_pin && !first_output_pin_o)
		else $error("first pins taken while disabled");
	a_gpio_second: assert property (!en2 |-> !pin_owned.second_output_pin
		&& !pin_owned.second_internal_input_pin && !second_output_pin_o)
		else $error("second pins taken while disabled");
	a_shared_pin: assert property (en1 || en2 |-> pin_owned.shared_input_pin == sh)
		else $error("shared pin ownership wrong");
	a_int_first: assert property (en1 |-> pin_owned.first_internal_input_pin == trim_cfg_first.input_select)
		else $error("first internal pin ownership wrong");
	a_out_first: assert property (en1 && pin_owned.first_output_pin
		|-> first_output_pin_o == $past(comparator_result[0], 2))
		else $error("first output pin not the result");
	a_out_second: assert property (en2 && pin_owned.second_output_pin
		|-> second_output_pin_o == $past(comparator_result[1], 2))
		else $error("second output pin not the result");
endmodule

bind ccal_ctrl ccal_ctrl_assertions ccal_ctrl_assertions_inst (.aclk, .aresetn,
	.comparator_result, .switches, .trim_cfg_first, .trim_cfg_second, .pin_owned,
	.first_output_pin_o, .second_output_pin_o);

// file: ccal_analog_model.sv
// stand-in for the two analog comparators behind the switch network
// assumes trip points are arbitrary; outside calibration the bench sets levels
`timescale 1ns/10ps
module ccal_analog_model
	import ccal_pkg::*;
#(
	parameter logic [4:0] TRIP1 = 5'h0c,
	parameter logic [4:0] TRIP2 = 5'h15
)(
	input  wire ccal_switch_t  sw,
	input  wire ccal_cmp_cfg_t cfg1,
	input  wire ccal_cmp_cfg_t cfg2,
	input  wire logic [1:0]    level,
	output logic      [1:0]    result
);
	// shorted inputs trip only once the trim reaches TRIP1 or TRIP2
	// inputs shorted, so only the trim decides the level
	assign result[0] = (sw.common_mode_short_switch && cfg1.offset_mode) ?
		(cfg1.trim >= TRIP1) : level[0];
	assign result[1] = (sw.common_mode_short_switch && cfg2.offset_mode) ?
		(cfg2.trim >= TRIP2) : level[1];
endmodule

// file: ccal_ctrl_bench.sv
// self-checking bench for the comparator control block
// assumes ccal_ctrl beside its analog model on one 100 mhz clock
`timescale 1ns/10ps
`include "ccal_defs.svh"
module ccal_ctrl_bench
	import ccal_pkg::*;
;
	localparam logic [4:0] TRIP1 = 5'h0c;
	localparam logic [4:0] TRIP2 = 5'h15;
	logic          aclk = 0;
	logic          aresetn = 0;
	logic [11:0]   awaddr = 0, araddr = 0;
	logic          awvalid = 0, wvalid = 0, arvalid = 0, bready = 1, rready = 1;
	logic [31:0]   wdata = 0, rdata;
	logic [3:0]    wstrb = 0;
	logic          awready, wready, bvalid, arready, rvalid, po1, po2;
	logic [1:0]    bresp, rresp, res, lvl = 0;
	ccal_switch_t  sw;
	ccal_cmp_cfg_t cf1, cf2;
	ccal_pin_t     pins;
	int            mismatches = 0, checked = 0, seed = 37;
	logic [6:0]    t1 = 7'h10, t2 = 7'h10;
	logic [2:0]    c1 = 3'h0, c2 = 3'h2, rt = 3'h0;

	always #5 aclk = ~aclk;

	ccal_ctrl ccal_ctrl_inst (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.comparator_result(res), .switches(sw), .trim_cfg_first(cf1), .trim_cfg_second(cf2),
		.pin_owned(pins), .first_output_pin_o(po1), .second_output_pin_o(po2));
	ccal_analog_model #(.TRIP1(TRIP1), .TRIP2(TRIP2)) ccal_analog_model_inst (.sw,
		.cfg1(cf1), .cfg2(cf2), .level(lvl), .result(res));

	task automatic give_verdict();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	// ready sampled at negedge equals what the next rising edge sees
	task automatic wr(input int i, input logic [31:0] d, input logic [3:0] s);
		int n;
		logic ta, tw, tb;
		logic [1:0] r;
		awaddr <= 12'(i * 4);
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		n = 0;
		tb = 0;
		while (!tb && n < 50) begin
			@(negedge aclk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
			n++;
		end
		chk("bvalid", 32'h0000_0001, 32'(tb));
		chk("bresp", 32'((i < 5) ? `CCAL_RESP_OKAY : `CCAL_RESP_SLVERR), 32'(r));
		if (s[0]) case (i)
			0: t1 = d[6:0];
			1: c1 = d[2:0];
			2: t2 = d[6:0];
			3: c2 = d[2:0];
			4: rt = d[2:0];
			default: ;
		endcase
	endtask

	task automatic rchk(input int i, input logic [31:0] e);
		int n;
		logic ta, tr;
		logic [31:0] d;
		logic [1:0] r;
		araddr <= 12'(i * 4);
		arvalid <= 1'b1;
		n = 0;
		tr = 0;
		while (!tr && n < 50) begin
			@(negedge aclk);
			ta = arvalid & arready;
			tr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta)
				arvalid <= 1'b0;
			n++;
		end
		chk("rvalid", 32'h0000_0001, 32'(tr));
		chk("rresp", 32'((i < 5) ? `CCAL_RESP_OKAY : `CCAL_RESP_SLVERR), 32'(r));
		chk("rdata", e, d);
	endtask

	task automatic check_all();
		logic sh, s1, s2, a1, a2, cal, rs, r1, r2;
		repeat (4) @(posedge aclk);
		@(negedge aclk);
		sh = rt[0] | t1[6] | t2[6];
		s1 = c1[1] | t1[6];
		s2 = c2[1] | t2[6];
		a1 = rt[1] & !sh;
		a2 = rt[2] & !sh & !a1;
		cal = t1[6] | t2[6];
		rs = t1[6] ? t1[5] : t2[5];
		r1 = t1[6] ? (t1[4:0] >= TRIP1) : lvl[0];
		r2 = t2[6] ? (t2[4:0] >= TRIP2) : lvl[1];
		chk("sw", 32'({sh, s1, s2, !cal | rs, !cal | !rs, cal, a1, a2}), 32'(sw));
		chk("cfg1", 32'({t1[4:0], t1[5], t1[6], c1[0], s1, c1[2]}), 32'(cf1));
		chk("cfg2", 32'({t2[4:0], t2[5], t2[6], c2[0], s2, c2[2]}), 32'(cf2));
		chk("pins", 32'({sh & (c1[0] | c2[0]), c1[0] & c1[2], c2[0] & c2[2],
			c1[0] & s1, c2[0] & s2}), 32'(pins));
		chk("outs", 32'({c1[0] & c1[2] & r1, c2[0] & c2[2] & r2}), 32'({po1, po2}));
		@(posedge aclk);
		rchk(0, 32'({r1, t1}));
		rchk(1, 32'({c1[2], s1, c1[0]}));
		rchk(2, 32'({r2, t2}));
		rchk(3, 32'({c2[2], s2, c2[0]}));
		rchk(4, 32'({a2, a1, sh}));
		rchk(5, 32'h0000_0000);
	endtask

	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check_all();
		wr(1, 32'h0000_0005, 4'hf);
		wr(3, 32'h0000_0005, 4'hf);
		wr(4, 32'h0000_0002, 4'hf);
		check_all();
		for (int k = 0; k < 2; k++) begin
			for (int t = 0; t < 32; t++) begin
				wr(2 * k, 32'(8'h40 | 8'(k << 5) | 8'(t)), 4'h1);
				check_all();
				if (t >= int'(k ? TRIP2 : TRIP1))
					break;
			end
			wr(2 * k, 32'(k << 5), 4'h1);
			check_all();
		end
		for (int n = 0; n < 60; n++) begin
			lvl <= 2'($random(seed));
			wr($unsigned($random(seed)) % 6, $random(seed), 4'($random(seed)));
			check_all();
		end
		give_verdict();
	end

	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		give_verdict();
	end
endmodule
